// file: ppio_top.sv
// Three-port parallel I/O block with AXI4-Lite register access
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module ppio_top
    import ppio_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  pa_in,
    output logic [7:0]       pa_out,
    output logic [7:0]       pa_oe_n,
    input  wire logic [7:0]  pb_in,
    output logic [7:0]       pb_out,
    output logic [7:0]       pb_oe_n,
    input  wire logic [7:0]  pc_in,
    output logic [7:0]       pc_out,
    output logic [7:0]       pc_oe_n,
    output logic             xcvr_dir_in,
    output logic             nmi_gate,
    output logic             wait_req,
    output logic             timer0_gate,
    output logic             timer1_gate,
    output logic             override_req_n,
    output logic             system_irq_out,
    output logic             sec_txd,
    output logic             indicator_lamp,
    output logic             power_fail_flag
);
    // Pin synchronisers
    logic [7:0]   pa_s1_q;
    logic [7:0]   pa_s2_q;
    logic [7:0]   pb_s1_q;
    logic [7:0]   pb_s2_q;
    logic [7:0]   pc_s1_q;
    logic [7:0]   pc_s2_q;
    // Port data latches and software-written values
    logic [7:0]   pa_lat_q;
    logic [7:0]   pa_lat_d;
    logic [7:0]   pb_lat_q;
    logic [7:0]   pb_lat_d;
    logic [7:0]   pa_wr_q;
    logic [7:0]   pa_wr_d;
    logic [7:0]   pb_wr_q;
    logic [7:0]   pb_wr_d;
    logic [7:0]   pc_wr_q;
    logic [7:0]   pc_wr_d;
    logic [15:0]  mode_q;
    logic [15:0]  mode_d;
    // Handshake flags
    logic         ibfa_q;
    logic         ibfa_d;
    logic         obfa_n_q;
    logic         obfa_n_d;
    logic         inta_q;
    logic         inta_d;
    logic         ibfb_q;
    logic         ibfb_d;
    logic         obfb_n_q;
    logic         obfb_n_d;
    logic         intb_q;
    logic         intb_d;
    logic         stba_q;
    logic         acka_q;
    logic         stbb_q;
    logic         ackb_q;
    // Bus answer state
    logic         bvalid_q;
    logic         bvalid_d;
    logic         rvalid_q;
    logic         rvalid_d;
    logic [1:0]   bresp_q;
    logic [1:0]   bresp_d;
    logic [1:0]   rresp_q;
    logic [1:0]   rresp_d;
    logic [31:0]  rdata_q;
    logic [31:0]  rdata_d;
    port_a_mode_t amode;
    logic         b_hs;
    logic         b_in;
    logic         a_in;
    logic         wr_go;
    logic         rd_go;
    logic [7:0]   pc_view;
    logic [7:0]   pc_hs_oe_n;
    logic [7:0]   pc_hs_val;
    logic [7:0]   fn_en;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pa_s1_q <= 8'h00;
            pa_s2_q <= 8'h00;
            pb_s1_q <= 8'h00;
            pb_s2_q <= 8'h00;
            // Idle high, so no false strobe or acknowledge after reset
            pc_s1_q <= 8'hFF;
            pc_s2_q <= 8'hFF;
        end else begin
            pa_s1_q <= pa_in;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= pb_in;
            pb_s2_q <= pb_s1_q;
            pc_s1_q <= pc_in;
            pc_s2_q <= pc_s1_q;
        end
    end

    assign amode = port_a_mode_t'(mode_q[MODE_A_LSB +: 2]);
    assign a_in  = mode_q[MODE_A_DIR];
    assign b_hs  = mode_q[MODE_B_HS];
    assign b_in  = mode_q[MODE_B_DIR];
    assign fn_en = mode_q[MODE_FUNC_EN +: MODE_FUNC_W];

    // Handshake pin map; 1 in oe_n marks a C bit owned as input or free
    always_comb begin
        pc_hs_oe_n = 8'hFF;
        pc_hs_val  = 8'h00;
        if (b_hs) begin
            pc_hs_oe_n[0] = 1'b0;
            pc_hs_val[0]  = intb_q;
            pc_hs_oe_n[1] = 1'b0;
            pc_hs_val[1]  = b_in ? ibfb_q : obfb_n_q;
        end
        if (amode != A_BASIC) begin
            pc_hs_oe_n[3] = 1'b0;
            pc_hs_val[3]  = inta_q;
        end
        if (amode == A_STROBED_IN || amode == A_BIDIR) begin
            pc_hs_oe_n[5] = 1'b0;
            pc_hs_val[5]  = ibfa_q;
        end
        if (amode == A_LATCHED_OUT || amode == A_BIDIR) begin
            pc_hs_oe_n[7] = 1'b0;
            pc_hs_val[7]  = obfa_n_q;
        end
    end

    // Port C view for software: handshake lines, else live or latched
    always_comb begin
        pc_view = 8'h00;
        for (int i = 0; i < 8; i++) begin
            pc_view[i] = pc_oe_n[i] ? pc_s2_q[i] : pc_out[i];
        end
    end

    // Strobe and acknowledge pins, active low, synchronised
    always_comb begin
        stba_q = pc_s2_q[4];
        acka_q = pc_s2_q[6];
        stbb_q = pc_s2_q[2];
        ackb_q = pc_s2_q[2];
    end

    // Address and data are taken together; a lone half simply waits
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign rd_go = s_axi_arvalid && !rvalid_q;

    // Handshake and register next state
    always_comb begin
        pa_lat_d = pa_lat_q;
        pb_lat_d = pb_lat_q;
        pa_wr_d = pa_wr_q;
        pb_wr_d = pb_wr_q;
        pc_wr_d = pc_wr_q;
        mode_d = mode_q;
        ibfa_d = ibfa_q;
        obfa_n_d = obfa_n_q;
        ibfb_d = ibfb_q;
        obfb_n_d = obfb_n_q;
        bvalid_d = bvalid_q && !s_axi_bready;
        rvalid_d = rvalid_q && !s_axi_rready;
        bresp_d = bresp_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        // Read side first so a strobe in the same cycle still wins
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            case (s_axi_araddr[3:0])
                ADDR_PORT_A: begin
                    rdata_d[7:0] = (amode == A_BASIC && a_in)
                                   ? pa_s2_q : pa_lat_q;
                    ibfa_d = 1'b0;
                end
                ADDR_PORT_B: begin
                    rdata_d[7:0] = (!b_hs && b_in) ? pb_s2_q : pb_lat_q;
                    if (b_hs) ibfb_d = 1'b0;
                end
                ADDR_PORT_C: rdata_d[7:0] = pc_view;
                ADDR_MODE:   rdata_d[15:0] = mode_q;
                default:     rresp_d = RESP_SLVERR;
            endcase
            if (s_axi_araddr[31:4] != 28'h0) rresp_d = RESP_SLVERR;
        end
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d  = RESP_OKAY;
            if (s_axi_awaddr[31:4] != 28'h0) begin
                bresp_d = RESP_SLVERR;
            end else begin
                case (s_axi_awaddr[3:0])
                    ADDR_PORT_A: if (s_axi_wstrb[0]) begin
                        pa_wr_d  = s_axi_wdata[7:0];
                        obfa_n_d = 1'b0;
                    end
                    ADDR_PORT_B: if (s_axi_wstrb[0]) begin
                        pb_wr_d  = s_axi_wdata[7:0];
                        obfb_n_d = !(b_hs && !b_in);
                    end
                    ADDR_PORT_C: if (s_axi_wstrb[0]) pc_wr_d = s_axi_wdata[7:0];
                    ADDR_MODE: begin
                        if (s_axi_wstrb[0]) mode_d[7:0]  = s_axi_wdata[7:0];
                        if (s_axi_wstrb[1]) mode_d[15:8] = s_axi_wdata[15:8];
                    end
                    default: bresp_d = RESP_SLVERR;
                endcase
            end
        end
        // Port A strobe latches input and sets buffer full
        if ((amode == A_STROBED_IN || amode == A_BIDIR) && !stba_q) begin
            pa_lat_d = pa_s2_q;
            ibfa_d   = 1'b1;
        end
        if ((amode == A_LATCHED_OUT || amode == A_BIDIR) && !acka_q)
            obfa_n_d = 1'b1;
        if (b_hs && b_in && !stbb_q) begin
            pb_lat_d = pb_s2_q;
            ibfb_d   = 1'b1;
        end
        if (b_hs && !b_in && !ackb_q)
            obfb_n_d = 1'b1;
        // Basic mode keeps the flags idle so a later switch starts clean
        if (amode == A_BASIC) begin
            ibfa_d = 1'b0;
            obfa_n_d = 1'b1;
        end
        if (!b_hs) begin
            ibfb_d = 1'b0;
            obfb_n_d = 1'b1;
        end
    end

    // Interrupts follow buffer state (strobe done, or ack done in A latched output and B handshake output)
    // Registered, so the request pins change one cycle after the flags
    always_comb begin
        inta_d = 1'b0;
        intb_d = 1'b0;
        case (amode)
            A_STROBED_IN:  inta_d = ibfa_q;
            A_LATCHED_OUT: inta_d = obfa_n_q;
            A_BIDIR:       inta_d = ibfa_q;
            default:       inta_d = 1'b0;
        endcase
        if (b_hs) begin
            intb_d = b_in ? ibfb_q : obfb_n_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pa_lat_q <= 8'h00;
            pb_lat_q <= 8'h00;
            pa_wr_q <= 8'h00;
            pb_wr_q <= 8'h00;
            pc_wr_q <= 8'h00;
            mode_q <= MODE_RESET;
            ibfa_q <= 1'b0;
            obfa_n_q <= 1'b1;
            inta_q <= 1'b0;
            ibfb_q <= 1'b0;
            obfb_n_q <= 1'b1;
            intb_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            pa_lat_q <= pa_lat_d;
            pb_lat_q <= pb_lat_d;
            pa_wr_q <= pa_wr_d;
            pb_wr_q <= pb_wr_d;
            pc_wr_q <= pc_wr_d;
            mode_q <= mode_d;
            ibfa_q <= ibfa_d;
            obfa_n_q <= obfa_n_d;
            inta_q <= inta_d;
            ibfb_q <= ibfb_d;
            obfb_n_q <= obfb_n_d;
            intb_q <= intb_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // Port C drive: handshake bits override, basic bits by group
    always_comb begin
        pc_out  = pc_wr_q;
        pc_oe_n = 8'hFF;
        for (int i = 0; i < 8; i++) begin
            if (i < 4) begin
                // Lower group bits 0 to 2 free only with B basic, bit 3 only with A basic
                pc_oe_n[i] = mode_q[MODE_CL_DIR];
            end else begin
                pc_oe_n[i] = mode_q[MODE_CU_DIR];
            end
        end
        if (amode == A_BIDIR) pc_oe_n[0] = 1'b1;
        // Bit 3 reserved whenever A is not basic
        for (int i = 0; i < 8; i++) begin
            if (!pc_hs_oe_n[i]) begin
                pc_oe_n[i] = 1'b0;
                pc_out[i]  = pc_hs_val[i];
            end
        end
        if (b_hs) pc_oe_n[2] = 1'b1;
        if (amode == A_STROBED_IN || amode == A_BIDIR) pc_oe_n[4] = 1'b1;
        if (amode == A_LATCHED_OUT || amode == A_BIDIR) pc_oe_n[6] = 1'b1;
    end

    // Port A and B drive
    always_comb begin
        xcvr_dir_in = (amode == A_BIDIR) ? acka_q
                    : (fn_en[FN_DIR] ? pc_wr_q[0] : a_in);
        pa_out  = pa_wr_q;
        pa_oe_n = xcvr_dir_in ? 8'hFF : 8'h00;
        if (amode == A_STROBED_IN) pa_oe_n = 8'hFF;
        pb_out  = pb_wr_q;
        pb_oe_n = b_in ? 8'hFF : 8'h00;
    end

    // Board control functions taken from written port C bits; power fail comes from the synchronised bit 7 pin
    // Software keeps one enable per bit; two on one bit share its value
    // Lamp follows the driven bit 3, so a handshake use shows there too
    always_comb begin
        nmi_gate       = fn_en[FN_NMI]    ? pc_wr_q[1] : 1'b1;
        wait_req       = fn_en[FN_WAIT]   && pc_wr_q[2];
        timer0_gate    = fn_en[FN_GATE0]  ? pc_wr_q[4] : 1'b1;
        timer1_gate    = fn_en[FN_GATE1]  ? pc_wr_q[5] : 1'b1;
        override_req_n = !(fn_en[FN_OVR]  && pc_wr_q[6]);
        system_irq_out = fn_en[FN_SYSIRQ] && pc_wr_q[7];
        sec_txd        = fn_en[FN_STXD]   ? pc_wr_q[7] : 1'b1;
        indicator_lamp = mode_q[MODE_LAMP] && pc_out[3];
        power_fail_flag = !pc_s2_q[7];
    end

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
endmodule

// file: ppio_pkg.sv
// Constants and types for the three-port parallel I/O block
package ppio_pkg;
    localparam logic [3:0] ADDR_PORT_A = 4'h0;
    localparam logic [3:0] ADDR_PORT_B = 4'h4;
    localparam logic [3:0] ADDR_PORT_C = 4'h8;
    localparam logic [3:0] ADDR_MODE   = 4'hC;
    // Mode register fields
    localparam int MODE_A_LSB   = 0;  // 2 bits: port A mode
    localparam int MODE_A_DIR   = 2;  // basic: 1 = input
    localparam int MODE_B_HS    = 3;  // port B handshake mode
    localparam int MODE_B_DIR   = 4;  // 1 = input
    localparam int MODE_CL_DIR  = 5;  // lower C basic direction
    localparam int MODE_CU_DIR  = 6;  // upper C basic direction
    localparam int MODE_LAMP    = 7;  // lamp link enable
    localparam int MODE_FUNC_EN = 8;  // board function enable
    localparam int MODE_FUNC_W  = 8;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    // Board function enable bit positions in the mode function field (from mode bit 8)
    localparam int FN_DIR     = 0;
    localparam int FN_NMI     = 1;
    localparam int FN_WAIT    = 2;
    localparam int FN_GATE0   = 3;
    localparam int FN_GATE1   = 4;
    localparam int FN_OVR     = 5;
    localparam int FN_SYSIRQ  = 6;
    localparam int FN_STXD    = 7;
    typedef enum logic [1:0] {
        A_BASIC, A_STROBED_IN, A_LATCHED_OUT, A_BIDIR
    } port_a_mode_t;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: ppio_top_properties.sv
// Checker for bus answers and board-function pins of the parallel I/O block
module ppio_top_checker
    import ppio_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0]  pc_in,
    input wire logic [7:0]  pc_out,
    input wire logic        xcvr_dir_in,
    input wire logic        nmi_gate,
    input wire logic        wait_req,
    input wire logic        timer0_gate,
    input wire logic        override_req_n,
    input wire logic        indicator_lamp,
    input wire logic        power_fail_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mode_q;
    logic [15:0] mode_d;
    // Shadow of the mode register, so pin checks know what is enabled
    always_comb begin
        mode_d = mode_q;
        if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
            s_axi_awaddr == {28'h0, ADDR_MODE}) begin
            mode_d = s_axi_wdata[15:0];
        end
    end
    always_ff @(posedge clk_sys) begin
        mode_q <= nrst ? mode_d : MODE_RESET;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    sequence wr_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    endsequence
    sequence rd_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
        else $error("write not answered after one cycle");
    rd_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    xcvr_follow_a: assert property (
        mode_q[8] && mode_q[1:0] != 2'h3 |-> xcvr_dir_in == pc_out[0])
        else $error("transceiver direction differs from its bit");
    nmi_follow_a: assert property (mode_q[9] |-> nmi_gate == pc_out[1])
        else $error("nmi gate differs from its bit");
    wait_follow_a: assert property (mode_q[10] |-> wait_req == pc_out[2])
        else $error("wait line differs from its bit");
    gate_follow_a: assert property (mode_q[11] |-> timer0_gate == pc_out[4])
        else $error("timer gate differs from its bit");
    ovr_follow_a: assert property (mode_q[13] |-> override_req_n == !pc_out[6])
        else $error("override differs from its bit");
    lamp_follow_a: assert property (mode_q[7] |-> indicator_lamp == pc_out[3])
        else $error("lamp differs from bit 3");
    pfail_set_a: assert property (!pc_in[7] [*4] |-> power_fail_flag)
        else $error("power fail not reported");
    pfail_clear_a: assert property (pc_in[7] [*4] |-> !power_fail_flag)
        else $error("power fail reported while sense high");
endmodule
bind ppio_top ppio_top_checker i_ppio_top_checker (.*);

// file: ppio_peripheral.sv
// Behavioural model of the peripheral on the parallel connector
module ppio_peripheral (
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe_n,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe_n,
    input  wire logic [7:0] pc_out,
    input  wire logic [7:0] pc_oe_n,
    input  wire logic [7:0] dev_pa,
    input  wire logic [7:0] dev_pb,
    input  wire logic [7:0] dev_pc,
    input  wire logic       pf_n,
    output logic [7:0]      pa_in,
    output logic [7:0]      pb_in,
    output logic [7:0]      pc_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driven pins read back the block's value; released pins take ours
    assign pa_in = (pa_out & ~pa_oe_n) | (dev_pa & pa_oe_n);
    assign pb_in = (pb_out & ~pb_oe_n) | (dev_pb & pb_oe_n);
    // Bit 7 carries the external power-fail latch; bit 6 the acknowledge
    assign pc_in = (pc_out & ~pc_oe_n) | ({pf_n, dev_pc[6:0]} & pc_oe_n);
endmodule

// file: ppio_top_test.sv
// Self-checking bench for the parallel I/O block
module ppio_top_test
    import ppio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'h0, nrst = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n;
    logic [7:0]  pc_in, pc_out, pc_oe_n;
    logic        xcvr_dir_in, nmi_gate, wait_req, timer0_gate, timer1_gate;
    logic        override_req_n, system_irq_out, sec_txd, indicator_lamp;
    logic        power_fail_flag;
    logic [7:0]  dev_pa = 8'h00, dev_pb = 8'h00, dev_pc = 8'hFF;
    logic        pf_n = 1'h1;
    int          err_total = 0, compares = 0;
    logic [7:0]  p;
    ppio_top i_ppio_top (.*);
    ppio_peripheral i_ppio_peripheral (.*);
    always #25 clk_sys = ~clk_sys;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic timeout();
        err_total++;
        $display("BAD %0t bus answer never came", $time);
        results();
    endtask
    task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        if (n == 40) timeout();
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [31:0] a, exp, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        if (n == 40) timeout();
        s_axi_rready <= 1'h0;
        chk(s_axi_rresp, er);
        if (er == RESP_OKAY) chk(s_axi_rdata[15:0], exp[15:0]);
        @(posedge clk_sys);
    endtask
    // Strobe or acknowledge pulse, held long enough to pass the synchroniser
    task automatic pulse(input int b);
        dev_pc[b] <= 1'h0;
        tick(3);
        dev_pc[b] <= 1'h1;
        tick(4);
    endtask
    // One handshake mode: buffer flag from an input strobe or an output write
    task automatic hs(input logic [15:0] m, input logic [31:0] a, exp,
                      input int stb, flg, input bit is_in);
        wr(ADDR_MODE, m, RESP_OKAY);
        tick(3);
        if (is_in) begin
            pulse(stb);
            chk(pc_out[flg], 1'h1);
            rd(a, exp, RESP_OKAY);
            chk(pc_out[flg], 1'h0);
        end else begin
            chk(pc_out[flg], 1'h1);
            wr(a, exp, RESP_OKAY);
            chk(pc_out[flg], 1'h0);
            pulse(stb);
            chk(pc_out[flg], 1'h1);
        end
    endtask
    initial begin
        tick(20);
        nrst <= 1'h1;
        @(posedge clk_sys);
        rd(ADDR_MODE, MODE_RESET, RESP_OKAY);
        rd(32'h10, 32'h0, RESP_SLVERR);
        wr(32'h10, 32'h0, RESP_SLVERR);
        $display("Test registers done");
        wr(ADDR_PORT_A, 32'h5A, RESP_OKAY);
        tick(2);
        chk(pa_out, 8'h5A);
        chk(pa_oe_n, 8'h00);
        wr(ADDR_MODE, 32'h14, RESP_OKAY);
        dev_pa <= 8'hC3;
        dev_pb <= 8'h3C;
        tick(3);
        rd(ADDR_PORT_A, 32'hC3, RESP_OKAY);
        rd(ADDR_PORT_B, 32'h3C, RESP_OKAY);
        $display("Test basic ports done");
        for (int i = 0; i < 2; i++) begin
            p = i ? 8'hAA : 8'h55;
            wr(ADDR_MODE, 32'h3F00, RESP_OKAY);
            wr(ADDR_PORT_C, p, RESP_OKAY);
            chk({override_req_n, timer1_gate, timer0_gate, wait_req, nmi_gate,
                 xcvr_dir_in}, {~p[6], p[5], p[4], p[2], p[1], p[0]});
            wr(ADDR_MODE, 32'h4000, RESP_OKAY);
            chk(system_irq_out, p[7]);
            wr(ADDR_MODE, 32'h8000, RESP_OKAY);
            chk(sec_txd, p[7]);
            wr(ADDR_MODE, 32'h0080, RESP_OKAY);
            chk(indicator_lamp, p[3]);
        end
        $display("Test board functions done");
        wr(ADDR_MODE, 32'h0040, RESP_OKAY);
        pf_n <= 1'h0;
        tick(4);
        chk(power_fail_flag, 1'h1);
        pf_n <= 1'h1;
        tick(4);
        chk(power_fail_flag, 1'h0);
        $display("Test power fail done");
        hs(16'h0001, ADDR_PORT_A, 32'hC3, 4, 5, 1'b1);
        hs(16'h0002, ADDR_PORT_A, 32'h77, 6, 7, 1'b0);
        hs(16'h0018, ADDR_PORT_B, 32'h3C, 2, 1, 1'b1);
        hs(16'h0008, ADDR_PORT_B, 32'h77, 2, 1, 1'b0);
        $display("Test handshakes done");
        wr(ADDR_MODE, 32'h0003, RESP_OKAY);
        tick(4);
        chk(xcvr_dir_in, 1'h1);
        chk(pc_oe_n, 8'h51);
        dev_pc[6] <= 1'h0;
        tick(4);
        chk(xcvr_dir_in, 1'h0);
        dev_pc[6] <= 1'h1;
        tick(4);
        $display("Test bidirectional done");
        results();
    end
endmodule
